// [timer_pkg.sv]
// Shared constants, field positions and carrier types for the dual timer block.
package timer_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the APB side.
  localparam logic [7:0] ADDR_CONTROL   = 8'h88;
  localparam logic [7:0] ADDR_MODE      = 8'h8c;
  localparam logic [7:0] ADDR_T0_LOW    = 8'h90;
  localparam logic [7:0] ADDR_T0_HIGH   = 8'h94;
  localparam logic [7:0] ADDR_T1_LOW    = 8'h98;
  localparam logic [7:0] ADDR_T1_HIGH   = 8'h9c;
  localparam logic [7:0] ADDR_AUX_MODE  = 8'ha0;
  localparam logic [7:0] ADDR_AUX_ONE   = 8'ha4;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions.
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam int         CTRL_T1_FLAG   = 7;
  localparam int         CTRL_T1_RUN    = 6;
  localparam int         CTRL_T0_FLAG   = 5;
  localparam int         CTRL_T0_RUN    = 4;
  localparam int         MODE_T0_SELECT = 2;
  localparam int         AUX_MODE_BIT2  = 0;
  localparam int         AUX_TOGGLE_EN  = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer mode codes; bit 2 comes from the auxiliary mode register.
  localparam logic [2:0] MODE_13BIT     = 3'h0;
  localparam logic [2:0] MODE_16BIT     = 3'h1;
  localparam logic [2:0] MODE_RELOAD    = 3'h2;
  localparam logic [2:0] MODE_SPLIT     = 3'h3;
  localparam logic [2:0] MODE_PWM       = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting constants.
  localparam logic [4:0] PRESCALE_MAX   = 5'h1f;
  localparam logic [7:0] BYTE_MAX       = 8'hff;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam int         PWM_PERIOD     = 256;

  // Layout of the run and flag control register.
  typedef struct packed {
    logic       t1_flag;
    logic       t1_run;
    logic       t0_flag;
    logic       t0_run;
    logic [3:0] reserved;
  } control_type;

  // One counter step: overflow strobe plus the new high and low bytes.
  typedef struct packed {
    logic       overflow;
    logic [7:0] high;
    logic [7:0] low;
  } step_type;

endpackage

// [pin_edge_sync.sv]
// Two-stage synchroniser for the counter pin with a rising-edge strobe.
`timescale 1ns/1ns
module pin_edge_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  output logic      rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Only sync_reg and last_reg feed the edge detector; meta_reg may be metastable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;

endmodule

// [pin_driver.sv]
// Drives the counter pin for overflow toggling and for the PWM waveform.
`timescale 1ns/1ns
module pin_driver
  import timer_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       toggle_enable,
  input  wire logic       pwm_mode,
  input  wire logic       pwm_level,
  input  wire logic [7:0] reload_value,
  input  wire logic       overflow,
  output logic            pin_out_reg,
  output logic            pin_oe_reg
);

  logic toggle_seen_reg;
  logic pin_out_next;

  // PWM outranks toggling because both would fight for the same pin.
  always_comb
  begin
    pin_out_next = 1'b1;
    if (pwm_mode)
    begin
      if (reload_value == BYTE_ZERO)
        pin_out_next = 1'b1;
      else if (reload_value == BYTE_MAX)
        pin_out_next = 1'b0;
      else
        pin_out_next = pwm_level;
    end
    else if (toggle_enable)
    begin
      if (!toggle_seen_reg)
        pin_out_next = 1'b1;
      else if (overflow)
        pin_out_next = ~pin_out_reg;
      else
        pin_out_next = pin_out_reg;
    end
  end

  // Pin level and enable are registered so the pad sees no glitches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_reg     <= 1'b1;
      pin_oe_reg      <= 1'b0;
      toggle_seen_reg <= 1'b0;
    end
    else
    begin
      pin_out_reg     <= pin_out_next;
      pin_oe_reg      <= pwm_mode | toggle_enable;
      toggle_seen_reg <= toggle_enable;
    end
  end

endmodule

// [dual_timer_split_pwm_toggle.sv]
// Pair of 8-bit-core timers with split mode, PWM mode and pin toggling, on APB.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module dual_timer_split_pwm_toggle
  import timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  timer0_int_ack,
  input  wire logic                  timer1_int_ack,
  input  wire logic                  counter0_pin_in,
  output logic                       counter0_pin_out,
  output logic                       counter0_pin_oe,
  output logic                       timer0_overflow_flag,
  output logic                       timer1_overflow_flag,
  output logic                       timer0_flag_rise
);

  // Addresses are compared in full, so the bus must at least hold a byte address.
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32)
  begin : addr_width_check
    $error("ADDR_WIDTH must lie between 8 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One counting step for the classic modes: 13-bit, 16-bit and auto-reload.
  function automatic step_type count_step(input logic [1:0] mode,
                                          input logic [7:0] high,
                                          input logic [7:0] low);
    step_type s;
    s = '{overflow: 1'b0, high: high, low: low};
    case ({1'b0, mode})
      MODE_13BIT:
      begin
        // Upper three low bits are left alone; the prescaler is five bits.
        s.low[4:0] = low[4:0] + 5'h01;
        if (low[4:0] == PRESCALE_MAX)
        begin
          s.high     = high + 8'h01;
          s.overflow = (high == BYTE_MAX);
        end
      end
      MODE_16BIT:
      begin
        s.low = low + 8'h01;
        if (low == BYTE_MAX)
        begin
          s.high     = high + 8'h01;
          s.overflow = (high == BYTE_MAX);
        end
      end
      MODE_RELOAD:
      begin
        if (low == BYTE_MAX)
        begin
          s.low      = high;
          s.overflow = 1'b1;
        end
        else
          s.low = low + 8'h01;
      end
      default:
      begin
        s.overflow = 1'b0;
      end
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  control_type control_reg;
  control_type control_next;
  logic [7:0]  mode_reg;
  logic [7:0]  aux_mode_reg;
  logic [7:0]  aux_one_reg;
  logic [7:0]  t0_low_reg;
  logic [7:0]  t0_low_next;
  logic [7:0]  t0_high_reg;
  logic [7:0]  t0_high_next;
  logic [7:0]  t1_low_reg;
  logic [7:0]  t1_low_next;
  logic [7:0]  t1_high_reg;
  logic [7:0]  t1_high_next;
  logic [31:0] prdata_reg;
  logic [31:0] read_word;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        flag_rise_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: answer comes in the second access cycle, so read data is stable.
  logic access;
  logic commit;
  logic write_en;
  logic hit_control;
  logic hit_mode;
  logic hit_t0_low;
  logic hit_t0_high;
  logic hit_t1_low;
  logic hit_t1_high;
  logic hit_aux_mode;
  logic hit_aux_one;
  logic hit_any;

  assign access       = psel & penable;
  assign commit       = access & pready_reg;
  assign hit_control  = (paddr == ADDR_WIDTH'(ADDR_CONTROL));
  assign hit_mode     = (paddr == ADDR_WIDTH'(ADDR_MODE));
  assign hit_t0_low   = (paddr == ADDR_WIDTH'(ADDR_T0_LOW));
  assign hit_t0_high  = (paddr == ADDR_WIDTH'(ADDR_T0_HIGH));
  assign hit_t1_low   = (paddr == ADDR_WIDTH'(ADDR_T1_LOW));
  assign hit_t1_high  = (paddr == ADDR_WIDTH'(ADDR_T1_HIGH));
  assign hit_aux_mode = (paddr == ADDR_WIDTH'(ADDR_AUX_MODE));
  assign hit_aux_one  = (paddr == ADDR_WIDTH'(ADDR_AUX_ONE));
  assign hit_any      = hit_control | hit_mode | hit_t0_low | hit_t0_high
                      | hit_t1_low | hit_t1_high | hit_aux_mode | hit_aux_one;
  assign write_en     = commit & pwrite & hit_any;

  // Read multiplexer; unmapped addresses read zero and flag an error.
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (hit_control)
      read_word[7:0] = {control_reg[7:4], 4'h0};
    else if (hit_mode)
      read_word[7:0] = mode_reg;
    else if (hit_t0_low)
      read_word[7:0] = t0_low_reg;
    else if (hit_t0_high)
      read_word[7:0] = t0_high_reg;
    else if (hit_t1_low)
      read_word[7:0] = t1_low_reg;
    else if (hit_t1_high)
      read_word[7:0] = t1_high_reg;
    else if (hit_aux_mode)
      read_word[7:0] = {7'h00, aux_mode_reg[AUX_MODE_BIT2]};
    else if (hit_aux_one)
      read_word[7:0] = aux_one_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and count gating.
  logic [2:0] t0_mode;
  logic [1:0] t1_mode;
  logic       t0_split;
  logic       t0_pwm;
  logic       t0_classic;
  logic       t1_stopped;
  logic       t0_tick;
  logic       t0_count;
  logic       t1_count;
  logic       pin_rise;

  assign t0_mode    = {aux_mode_reg[AUX_MODE_BIT2], mode_reg[1:0]};
  assign t1_mode    = mode_reg[5:4];
  assign t0_split   = (t0_mode == MODE_SPLIT);
  assign t0_pwm     = (t0_mode == MODE_PWM);
  assign t0_classic = ~t0_mode[2] & ~t0_split;

  assign t0_tick    = mode_reg[MODE_T0_SELECT] ? pin_rise : 1'b1;
  assign t0_count   = control_reg.t0_run & t0_tick;
  assign t1_stopped = (t1_mode == MODE_SPLIT[1:0]);
  assign t1_count   = ~t1_stopped & (t0_split | control_reg.t1_run);

  pin_edge_sync u_pin_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (counter0_pin_in),
    .rise      (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Counter arithmetic for both timers.
  step_type t0_step;
  step_type t1_step;
  logic     t0_overflow;
  logic     split_high_overflow;
  logic     t1_overflow;
  logic     pwm_set;
  logic     pwm_clear;

  assign t1_step = count_step(t1_mode, t1_high_reg, t1_low_reg);

  // Timer 0 next state; reserved modes simply hold the count.
  always_comb
  begin
    t0_step             = count_step(t0_mode[1:0], t0_high_reg, t0_low_reg);
    t0_low_next         = t0_low_reg;
    t0_high_next        = t0_high_reg;
    t0_overflow         = 1'b0;
    split_high_overflow = 1'b0;
    pwm_set             = 1'b0;
    pwm_clear           = 1'b0;
    if (t0_classic && t0_count)
    begin
      t0_low_next  = t0_step.low;
      t0_high_next = t0_step.high;
      t0_overflow  = t0_step.overflow;
    end
    else if (t0_split)
    begin
      // low byte on timer 0 run
      if (t0_count)
      begin
        t0_low_next = t0_low_reg + 8'h01;
        t0_overflow = (t0_low_reg == BYTE_MAX);
      end
      // high byte on timer 1 run
      if (control_reg.t1_run)
      begin
        t0_high_next        = t0_high_reg + 8'h01;
        split_high_overflow = (t0_high_reg == BYTE_MAX);
      end
    end
    else if (t0_pwm && t0_count)
    begin
      t0_low_next = t0_low_reg + 8'h01;
      t0_overflow = (t0_low_reg == BYTE_MAX);
      pwm_clear   = t0_overflow;
      pwm_set     = (t0_low_next == t0_high_reg);
    end
    // Software writes to the count registers win over counting.
    if (write_en && hit_t0_low)
      t0_low_next = pwdata[7:0];
    if (write_en && hit_t0_high)
      t0_high_next = pwdata[7:0];
  end

  // Timer 1 next state.
  always_comb
  begin
    t1_low_next  = t1_low_reg;
    t1_high_next = t1_high_reg;
    t1_overflow  = 1'b0;
    if (t1_count)
    begin
      t1_low_next  = t1_step.low;
      t1_high_next = t1_step.high;
      t1_overflow  = t1_step.overflow;
    end
    if (write_en && hit_t1_low)
      t1_low_next = pwdata[7:0];
    if (write_en && hit_t1_high)
      t1_high_next = pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register: every hardware set is applied last so it beats any clear.
  logic t1_flag_set;

  assign t1_flag_set = t0_split ? split_high_overflow : t1_overflow;

  always_comb
  begin
    control_next = control_reg;
    if (timer0_int_ack && !t0_pwm)
      control_next.t0_flag = 1'b0;
    if (timer1_int_ack)
      control_next.t1_flag = 1'b0;
    if (pwm_clear)
      control_next.t0_flag = 1'b0;
    if (write_en && hit_control)
    begin
      control_next.t1_run  = pwdata[CTRL_T1_RUN];
      control_next.t0_run  = pwdata[CTRL_T0_RUN];
      control_next.t1_flag = pwdata[CTRL_T1_FLAG];
      control_next.t0_flag = pwdata[CTRL_T0_FLAG];
    end
    control_next.reserved = 4'h0;
    if ((t0_overflow && !t0_pwm) || pwm_set)
      control_next.t0_flag = 1'b1;
    if (t1_flag_set)
      control_next.t1_flag = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg  <= control_type'(RESET_BYTE);
      t0_low_reg   <= RESET_BYTE;
      t0_high_reg  <= RESET_BYTE;
      t1_low_reg   <= RESET_BYTE;
      t1_high_reg  <= RESET_BYTE;
    end
    else
    begin
      control_reg  <= control_next;
      t0_low_reg   <= t0_low_next;
      t0_high_reg  <= t0_high_next;
      t1_low_reg   <= t1_low_next;
      t1_high_reg  <= t1_high_next;
    end
  end

  // Mode and auxiliary registers change only on a committed write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg     <= RESET_BYTE;
      aux_mode_reg <= RESET_BYTE;
      aux_one_reg  <= RESET_BYTE;
    end
    else if (write_en)
    begin
      if (hit_mode)
        mode_reg <= pwdata[7:0];
      if (hit_aux_mode)
        aux_mode_reg <= {7'h00, pwdata[AUX_MODE_BIT2]};
      if (hit_aux_one)
        aux_one_reg <= pwdata[7:0];
    end
  end

  // Bus answer registers; pready pulses for one cycle per transfer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~hit_any;
      if (access && !pready_reg && !pwrite)
        prdata_reg <= read_word;
    end
  end

  // registered rise of timer 0 flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_rise_reg <= 1'b0;
    else
      flag_rise_reg <= control_next.t0_flag & ~control_reg.t0_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter pin output.
  pin_driver u_pin_driver
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .toggle_enable (aux_one_reg[AUX_TOGGLE_EN]),
    .pwm_mode      (t0_pwm),
    .pwm_level     (control_next.t0_flag),
    .reload_value  (t0_high_reg),
    .overflow      (t0_overflow),
    .pin_out_reg   (counter0_pin_out),
    .pin_oe_reg    (counter0_pin_oe)
  );

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign timer0_overflow_flag = control_reg.t0_flag;
  assign timer1_overflow_flag = control_reg.t1_flag;
  assign timer0_flag_rise     = flag_rise_reg;

endmodule

// [dual_timer_chk.sv]
// Concurrent checks on the bus answer and timer 0 flag outputs of the dual timer.
`timescale 1ns/1ns
module dual_timer_chk
#(
  parameter int ADDR_WIDTH = 8
)
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  counter0_pin_oe,
  input wire logic                  timer0_overflow_flag,
  input wire logic                  timer1_overflow_flag,
  input wire logic                  timer0_flag_rise
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // The slave always adds exactly one wait state, so a later answer means a broken decoder.
  apb_answer_a: assert property (psel && !penable |-> ##2 pready)
    else $error("bus answer not two cycles after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_sel_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Read data may only move while a read is in its access phase.
  rdata_hold_a: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");

  ////////////////////////////////////////////////////////////////////////////////
  // The rise strobe accompanies every flag rise in the same cycle and has no other cause.
  rise_pulse_a: assert property ($rose(timer0_overflow_flag) |-> timer0_flag_rise)
    else $error("flag rise not signalled");
  rise_cause_a: assert property (timer0_flag_rise |-> $rose(timer0_overflow_flag))
    else $error("rise strobe without flag");

  // Main scenarios reached.
  cover property (pslverr);
  cover property ($rose(timer1_overflow_flag));
  cover property ($rose(counter0_pin_oe));
endmodule

bind dual_timer_split_pwm_toggle dual_timer_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_i
(
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .counter0_pin_oe      (counter0_pin_oe),
  .timer0_overflow_flag (timer0_overflow_flag),
  .timer1_overflow_flag (timer1_overflow_flag),
  .timer0_flag_rise     (timer0_flag_rise)
);

// [tb_top.sv]
// Self-checking bench for the dual timer block.
`timescale 1ns/1ns
module tb_top
  import timer_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ack0;
  logic        ack1;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe;
  logic        flag0;
  logic        flag1;
  logic        rise0;
  int          error_cnt;
  int          cmp_count;
  int          seed;
  int          n1;
  int          n2;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  th;
  logic        v;

  dual_timer_split_pwm_toggle dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_int_ack(ack0), .timer1_int_ack(ack1), .counter0_pin_in(pin_in),
    .counter0_pin_out(pin_out), .counter0_pin_oe(pin_oe), .timer0_overflow_flag(flag0),
    .timer1_overflow_flag(flag1), .timer0_flag_rise(rise0)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock; a half period of 4 ns gives 125 MHz.
  always #4 pclk = ~pclk;

  // select kept clear.
  // Pin noise must not count, since software leaves the count source on the clock.
  always @(posedge pclk)
    pin_in <= 1'($random(seed));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycle, acknowledge and level measurement helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // The request stands until pready is seen at a rising edge; only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ack(input logic which);
    @(posedge pclk);
    ack0 <= !which;
    ack1 <= which;
    @(posedge pclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
  endtask

  // Counts cycles until the pin or the flag leaves its present level, stopping at 600.
  task automatic level_len(input logic use_pin, output int n);
    logic s;
    s = use_pin ? pin_out : flag0;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while ((use_pin ? pin_out : flag0) === s && n < 600);
  endtask

  function automatic int high_len(input logic [7:0] t);
    return 256 - int'(t);
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    pin_in = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    seed = 85641;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk({pin_oe, pin_out}, 32'h1);
    apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h0);
    apb(0, 8'hfc, 8'h00); chk({rd[30:0], er}, 32'h1);
    apb(1, ADDR_CONTROL, 8'h5f); apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h50);
    apb(1, ADDR_CONTROL, 8'h00);
    // split counters, timer 1 free in mode 1.
    apb(1, ADDR_MODE, 8'h13);
    apb(1, ADDR_T0_LOW, 8'hf8);
    apb(1, ADDR_T0_HIGH, 8'hf0);
    apb(1, ADDR_T1_LOW, 8'h00);
    apb(1, ADDR_CONTROL, 8'h10);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h30);
    apb(0, ADDR_T0_HIGH, 8'h00); chk(rd, 32'hf0);
    apb(0, ADDR_T1_LOW, 8'h00); chk(32'(rd != 32'h0), 32'h1);
    apb(1, ADDR_CONTROL, 8'h40);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'hc0);
    chk(flag1, 32'h1);
    ack(1'b1); apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h40);
    // timer 1 halted in its own mode 3.
    apb(1, ADDR_MODE, 8'h33);
    apb(1, ADDR_T1_LOW, 8'h12);
    repeat (8) @(posedge pclk);
    apb(0, ADDR_T1_LOW, 8'h00); chk(rd, 32'h12);
    // reserved codes 4, 5 and 7 hold the counter.
    apb(1, ADDR_CONTROL, 8'h10);
    apb(1, ADDR_AUX_MODE, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      if (m == 2)
        continue;
      apb(1, ADDR_MODE, 8'(m));
      apb(1, ADDR_T0_LOW, 8'h55);
      repeat (5) @(posedge pclk);
      apb(0, ADDR_T0_LOW, 8'h00); chk(rd, 32'h55);
    end
    // auto-reload with a random reload value.
    th = 8'h10 + 8'($random(seed) & 32'h7f);
    apb(1, ADDR_AUX_MODE, 8'h00);
    apb(1, ADDR_MODE, 8'h02);
    apb(1, ADDR_T0_HIGH, th);
    apb(1, ADDR_CONTROL, 8'h10);
    apb(1, ADDR_T0_LOW, 8'hfe);
    repeat (6) @(posedge pclk);
    apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h30);
    chk(flag0, 32'h1);
    apb(0, ADDR_T0_LOW, 8'h00); chk(32'(8'(rd[7:0] - th) < 8'd32), 32'h1);
    ack(1'b0); apb(0, ADDR_CONTROL, 8'h00); chk(rd, 32'h10);
    apb(1, ADDR_AUX_ONE, 8'h08);
    @(posedge pclk);
    @(negedge pclk);
    chk({pin_oe, pin_out}, 32'h3);
    level_len(1'b1, n1); chk(pin_out, 32'h0);
    level_len(1'b1, n2); chk(n2, high_len(th));
    apb(1, ADDR_AUX_ONE, 8'h00);
    // PWM periods at both ends and one random value.
    apb(1, ADDR_AUX_MODE, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      th = (k == 0) ? 8'h01 : (k == 1) ? 8'hfe : 8'h02 + 8'($random(seed) & 32'h7f);
      apb(1, ADDR_T0_HIGH, th);
      level_len(1'b0, n1);
      v = flag0;
      chk(rise0, 32'(v));
      chk({pin_oe, pin_out}, {31'h1, flag0});
      level_len(1'b0, n1);
      level_len(1'b0, n2);
      chk(v ? n1 : n2, high_len(th));
      chk(v ? n2 : n1, 32'(th));
    end
    for (int k = 0; k < 2; k++)
    begin
      apb(1, ADDR_T0_HIGH, (k == 0) ? 8'h00 : 8'hff);
      repeat (4) @(posedge pclk);
      level_len(1'b1, n1);
      chk(n1, 32'd600);
      chk(pin_out, 32'(k == 0));
    end
    report_and_stop();
  end

  // Watchdog; the whole sequence needs well under a tenth of this span.
  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule
